//--- rtl/sbl_map.svh
// constants of the burst and latency link: fields, codes, offsets, counts
`ifndef SBL_MAP_SVH
`define SBL_MAP_SVH
// ==========================================
// mode word fields
`define SBL_SPAN_LSB 0
`define SBL_ORDER_BIT 3
`define SBL_LAT_LSB 4
`define SBL_OPMODE_LSB 7
`define SBL_SINGLE_WR_BIT 9
// ==========================================
// mode codes
`define SBL_SPAN_1 3'h0
`define SBL_SPAN_2 3'h1
`define SBL_SPAN_4 3'h2
`define SBL_SPAN_8 3'h3
`define SBL_SPAN_FULL 3'h7
`define SBL_LAT_2 3'h2
`define SBL_LAT_3 3'h3
`define SBL_OPMODE_NORMAL 2'h0
`define SBL_PAGE_COLS 2048
// ==========================================
// controller registers (byte offsets)
`define SBL_REG_CMD 8'h00
`define SBL_REG_COL 8'h04
`define SBL_REG_MODE 8'h08
`define SBL_REG_COUNT 8'h0C
`define SBL_REG_WBASE 8'h10
`define SBL_REG_STATUS 8'h14
`define SBL_REG_RDATA 8'h18
`define SBL_REG_REGMODE 8'h1C
// command field values
`define SBL_OP_NONE 2'h0
`define SBL_OP_READ 2'h1
`define SBL_OP_WRITE 2'h2
`define SBL_OP_LOAD 2'h3
// status fields
`define SBL_ST_REFUSED_BIT 0
`define SBL_ST_BUSY_BIT 1
`define SBL_ST_LEVEL_LSB 8
// ==========================================
// reset values and timing
`define SBL_MODE_RST 12'h020
`define SBL_COUNT_RST 12'h001
`define SBL_MRD_CYC 2
`endif

//--- rtl/sbl_pkg.sv
// types and shared decode functions of the burst and latency link
package sbl_pkg;
  `include "sbl_map.svh"

  // ==========================================
  // types
  typedef enum logic [2:0] {
    cmd_nop = 3'h0,
    cmd_read = 3'h1,
    cmd_write = 3'h2,
    cmd_term = 3'h3,
    cmd_load = 3'h4
  } sbl_cmd_t;

  typedef enum logic [1:0] {
    st_idle = 2'h0,
    st_run = 2'h1,
    st_tail = 2'h3
  } sbl_state_t;

  // ==========================================
  // decode
  // span code to column mask (length minus one); reserved codes act as one column
  function automatic logic [10:0] sbl_span_mask(input logic [2:0] code);
    case (code)
      `SBL_SPAN_2: sbl_span_mask = 11'h001;
      `SBL_SPAN_4: sbl_span_mask = 11'h003;
      `SBL_SPAN_8: sbl_span_mask = 11'h007;
      `SBL_SPAN_FULL: sbl_span_mask = 11'(`SBL_PAGE_COLS - 1);
      default: sbl_span_mask = 11'h000;
    endcase
  endfunction : sbl_span_mask

  // latency code to clocks; reserved codes act as three
  function automatic logic [1:0] sbl_lat(input logic [2:0] code);
    sbl_lat = (code == `SBL_LAT_2) ? 2'h2 : 2'h3;
  endfunction : sbl_lat

  function automatic logic sbl_mode_legal(input logic [11:0] mode);
    logic [2:0] sp;
    logic [2:0] lt;
    sp = mode[`SBL_SPAN_LSB +: 3];
    lt = mode[`SBL_LAT_LSB +: 3];
    sbl_mode_legal = (sp <= `SBL_SPAN_8 || (sp == `SBL_SPAN_FULL && !mode[`SBL_ORDER_BIT]))
      && (lt == `SBL_LAT_2 || lt == `SBL_LAT_3)
      && (mode[`SBL_OPMODE_LSB +: 2] == `SBL_OPMODE_NORMAL);
  endfunction : sbl_mode_legal
endpackage : sbl_pkg

//--- rtl/sbl_if.sv
// link between the memory controller and the burst memory
`timescale 1ns/10ps
interface sbl_if #(parameter int DW = 8) ();
  sbl_pkg::sbl_cmd_t cmd;
  logic [11:0] addr;
  logic reg_mode;
  logic [DW-1:0] ctl_dq;
  logic ctl_dq_oe;
  logic [DW-1:0] dev_dq;
  logic dev_dq_oe;
  logic [DW-1:0] dq;

  // shared data lines resolved from the two enables
  assign dq = dev_dq_oe ? dev_dq : (ctl_dq_oe ? ctl_dq : '0);

  modport dev (input cmd, input addr, input reg_mode, input dq, output dev_dq, output dev_dq_oe);
  modport ctl (output cmd, output addr, output reg_mode, output ctl_dq, output ctl_dq_oe, input dq);
endinterface : sbl_if

//--- rtl/sbl_fifo.sv
// read data buffer with valid and ready on both sides
`timescale 1ns/10ps
module sbl_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32,
  parameter int LW = $clog2(DEPTH) + 1
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i,
  // fill level
  output logic [LW-1:0] level_o
);
  logic [W-1:0] store [DEPTH];
  logic [LW-1:0] wp;
  logic [LW-1:0] rp;
  logic push;
  logic pop;

  // depth must be a power of two: pointers wrap by overflow
  assign level_o = wp - rp;
  assign in_ready_o = (level_o != LW'(DEPTH));
  assign out_valid_o = (level_o != '0);
  assign out_data_o = store[rp[LW-2:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      store[wp[LW-2:0]] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (push) begin
        wp <= wp + 1'b1;
      end
      if (pop) begin
        rp <= rp + 1'b1;
      end
    end
  end
endmodule : sbl_fifo

//--- rtl/sbl_device.sv
// memory end: mode register, burst column sequencer, read latency pipe and one page of storage
`timescale 1ns/10ps
`include "sbl_map.svh"
module sbl_device #(
  parameter int DW = 8,
  parameter int COLS = `SBL_PAGE_COLS
) (
  // link
  sbl_if.dev mem,
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // state view
  output logic [11:0] mode_o,
  output logic burst_active_o
);
  // ==========================================
  // column order
  function automatic logic [10:0] burst_col(
    input logic [10:0] start,
    input logic [10:0] beat,
    input logic [2:0] code,
    input logic order
  );
    logic [10:0] m;
    logic [10:0] low;
    m = sbl_pkg::sbl_span_mask(code);
    // full page has no interleave; span one has an empty mask so order is moot
    if (order && code != `SBL_SPAN_FULL) begin
      low = start ^ beat;
    end else begin
      low = start + beat;
    end
    burst_col = (start & ~m) | (low & m);
  endfunction : burst_col

  // ==========================================
  // input register
  sbl_pkg::sbl_cmd_t cmd_q;
  logic [11:0] addr_q;
  logic reg_mode_q;
  sbl_pkg::sbl_cmd_t cmd_e;
  logic [11:0] addr_e;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_q <= sbl_pkg::cmd_nop;
      addr_q <= 12'h000;
      reg_mode_q <= 1'b0;
    end else begin
      cmd_q <= mem.cmd;
      addr_q <= mem.addr;
      reg_mode_q <= mem.reg_mode;
    end
  end

  // registered mode delays command and address one clock, data lines are not delayed
  always_comb begin
    if (reg_mode_q) begin
      cmd_e = cmd_q;
      addr_e = addr_q;
    end else begin
      cmd_e = mem.cmd;
      addr_e = mem.addr;
    end
  end

  // ==========================================
  // mode register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_o <= `SBL_MODE_RST;
    end else if (cmd_e == sbl_pkg::cmd_load) begin
      mode_o <= addr_e;
    end
  end

  // operating mode bits are stored but only the normal mode is built
  logic [2:0] span_code;
  logic order_bit;
  logic single_wr;
  logic [1:0] lat;
  assign span_code = mode_o[`SBL_SPAN_LSB +: 3];
  assign order_bit = mode_o[`SBL_ORDER_BIT];
  assign single_wr = mode_o[`SBL_SINGLE_WR_BIT];
  assign lat = sbl_pkg::sbl_lat(mode_o[`SBL_LAT_LSB +: 3]);

  // ==========================================
  // burst sequencer
  logic new_cmd;
  logic new_rd;
  logic [10:0] new_col;
  logic [10:0] start;
  logic [10:0] beat;
  logic [10:0] last_beat;
  logic [2:0] code_r;
  logic order_r;
  logic is_rd;
  logic [10:0] next_last;
  logic emit;
  logic emit_rd;
  logic [10:0] emit_col;

  assign new_rd = (cmd_e == sbl_pkg::cmd_read);
  assign new_cmd = new_rd || (cmd_e == sbl_pkg::cmd_write);
  // column address skips the auto precharge bit
  assign new_col = {addr_e[11], addr_e[9:0]};

  always_comb begin
    if (!new_rd && single_wr) begin
      next_last = 11'h000;
    end else begin
      next_last = sbl_pkg::sbl_span_mask(span_code);
    end
  end

  always_comb begin
    emit = 1'b0;
    emit_rd = 1'b0;
    emit_col = 11'h000;
    if (new_cmd) begin
      emit = 1'b1;
      emit_rd = new_rd;
      emit_col = new_col;
    end else if (burst_active_o && cmd_e != sbl_pkg::cmd_term) begin
      emit = 1'b1;
      emit_rd = is_rd;
      emit_col = burst_col(start, beat, code_r, order_r);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      burst_active_o <= 1'b0;
      start <= 11'h000;
      beat <= 11'h000;
      last_beat <= 11'h000;
      code_r <= `SBL_SPAN_1;
      order_r <= 1'b0;
      is_rd <= 1'b0;
    end else if (new_cmd) begin
      // a new command cuts any open burst short
      start <= new_col;
      beat <= 11'h001;
      last_beat <= next_last;
      code_r <= span_code;
      order_r <= order_bit;
      is_rd <= new_rd;
      burst_active_o <= (next_last != 11'h000);
    end else if (burst_active_o) begin
      if (cmd_e == sbl_pkg::cmd_term) begin
        burst_active_o <= 1'b0;
      end else begin
        beat <= beat + 11'h001;
        // full page mask is the whole row, so it runs until terminated
        if (beat == last_beat && code_r != `SBL_SPAN_FULL) begin
          burst_active_o <= 1'b0;
        end
      end
    end
  end

  // ==========================================
  // storage: one open row
  logic [DW-1:0] page [COLS];

  always_ff @(posedge ref_clk_i) begin
    if (emit && !emit_rd) begin
      page[emit_col] <= mem.dq;
    end
  end

  // ==========================================
  // read latency pipe
  logic [1:0] pipe_v;
  logic [10:0] pipe_c0;
  logic [10:0] pipe_c1;
  logic out_v;
  logic [10:0] out_c;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pipe_v <= 2'h0;
      pipe_c0 <= 11'h000;
      pipe_c1 <= 11'h000;
    end else begin
      pipe_v <= {pipe_v[0], emit && emit_rd};
      pipe_c0 <= emit_col;
      pipe_c1 <= pipe_c0;
    end
  end

  // word loaded at edge n+m-1 holds through edge n+m
  always_comb begin
    if (lat == 2'h2) begin
      out_v = pipe_v[0];
      out_c = pipe_c0;
    end else begin
      out_v = pipe_v[1];
      out_c = pipe_c1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem.dev_dq_oe <= 1'b0;
      mem.dev_dq <= '0;
    end else begin
      mem.dev_dq_oe <= out_v;
      mem.dev_dq <= out_v ? page[out_c] : '0;
    end
  end
endmodule : sbl_device

//--- rtl/sbl_ctrl.sv
// controller end: APB registers, command sequencer and read data buffer
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`include "sbl_map.svh"
module sbl_ctrl #(
  parameter int DW = 8,
  parameter int DEPTH = 32
) (
  // link
  sbl_if.ctl mem,
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);
  localparam int LW = $clog2(DEPTH) + 1;

  // ==========================================
  // registers and buffer
  logic [10:0] col_r;
  logic [11:0] mode_r;
  logic [11:0] mode_cur;
  logic [11:0] count_r;
  logic [DW-1:0] wbase_r;
  logic refused;
  logic [1:0] op_pend;
  logic pop_ok;
  sbl_pkg::sbl_state_t st;
  logic push;
  logic fifo_rdy;
  logic fifo_v;
  logic [DW-1:0] fifo_d;
  logic [LW-1:0] level;
  logic setup;
  logic wr_done;
  logic rd_done;
  logic mapped;
  logic busy;

  assign setup = psel_i && !penable_i;
  assign wr_done = psel_i && penable_i && pready_o && pwrite_i;
  assign rd_done = psel_i && penable_i && pready_o && !pwrite_i;
  assign busy = (st != sbl_pkg::st_idle) || (op_pend != `SBL_OP_NONE);
  assign mapped = (paddr_i[1:0] == 2'h0) && (paddr_i <= `SBL_REG_REGMODE);

  sbl_fifo #(.W(DW), .DEPTH(DEPTH)) u_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(push),
    .in_data_i(mem.dq),
    .in_ready_o(fifo_rdy),
    .out_valid_o(fifo_v),
    .out_data_o(fifo_d),
    .out_ready_i(rd_done && paddr_i == `SBL_REG_RDATA && pop_ok),
    .level_o(level)
  );

  // ==========================================
  // apb slave: no wait state, read data caught in setup
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pop_ok <= 1'b0;
    end else begin
      pready_o <= setup;
      pslverr_o <= setup && !mapped;
      pop_ok <= setup && fifo_v;
      if (setup) begin
        case (paddr_i)
          `SBL_REG_COL: prdata_o <= 32'(col_r);
          `SBL_REG_MODE: prdata_o <= 32'(mode_r);
          `SBL_REG_COUNT: prdata_o <= 32'(count_r);
          `SBL_REG_WBASE: prdata_o <= 32'(wbase_r);
          `SBL_REG_STATUS: prdata_o <= (32'(level) << `SBL_ST_LEVEL_LSB)
            | (32'(busy) << `SBL_ST_BUSY_BIT) | (32'(refused) << `SBL_ST_REFUSED_BIT);
          `SBL_REG_RDATA: prdata_o <= fifo_v ? 32'(fifo_d) : 32'h0000_0000;
          `SBL_REG_REGMODE: prdata_o <= 32'(mem.reg_mode);
          default: prdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      col_r <= 11'h000;
      mode_r <= `SBL_MODE_RST;
      count_r <= `SBL_COUNT_RST;
      wbase_r <= '0;
      mem.reg_mode <= 1'b0;
    end else if (wr_done) begin
      case (paddr_i)
        `SBL_REG_COL: col_r <= pwdata_i[10:0];
        `SBL_REG_MODE: mode_r <= pwdata_i[11:0];
        `SBL_REG_COUNT: count_r <= pwdata_i[11:0];
        `SBL_REG_WBASE: wbase_r <= pwdata_i[DW-1:0];
        // only change while idle: it shifts every link timing by one clock
        `SBL_REG_REGMODE: mem.reg_mode <= pwdata_i[0];
        default: ;
      endcase
    end
  end

  // ==========================================
  // burst sizing from the loaded mode
  logic full;
  logic [11:0] n_rd;
  logic [11:0] n_go;
  logic [12:0] m_lat;
  logic room;
  logic go;
  logic bad;

  assign full = (mode_cur[`SBL_SPAN_LSB +: 3] == `SBL_SPAN_FULL);
  always_comb begin
    if (full) begin
      n_rd = (count_r == 12'h000) ? 12'h001 : count_r;
    end else begin
      n_rd = 12'(sbl_pkg::sbl_span_mask(mode_cur[`SBL_SPAN_LSB +: 3])) + 12'h001;
    end
    if (op_pend == `SBL_OP_WRITE && mode_cur[`SBL_SINGLE_WR_BIT]) begin
      n_go = 12'h001;
    end else begin
      n_go = n_rd;
    end
  end
  assign m_lat = 13'(sbl_pkg::sbl_lat(mode_cur[`SBL_LAT_LSB +: 3])) + 13'(mem.reg_mode);
  // stalls the read until the buffer has room for the whole burst
  assign room = (13'(DEPTH) - 13'(level)) >= 13'(n_go);
  assign bad = (op_pend == `SBL_OP_LOAD) ? !sbl_pkg::sbl_mode_legal(mode_r)
    : ((op_pend == `SBL_OP_READ) && 13'(n_go) > 13'(DEPTH));
  assign go = (st == sbl_pkg::st_idle) && (op_pend != `SBL_OP_NONE) && !bad
    && (room || op_pend != `SBL_OP_READ);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op_pend <= `SBL_OP_NONE;
      refused <= 1'b0;
    end else begin
      if (go || (st == sbl_pkg::st_idle && bad)) begin
        op_pend <= `SBL_OP_NONE;
      end
      if (wr_done && paddr_i == `SBL_REG_CMD && !busy) begin
        op_pend <= pwdata_i[1:0];
      end
      // set wins over the software clear
      if ((wr_done && paddr_i == `SBL_REG_CMD && busy) || (st == sbl_pkg::st_idle && bad)) begin
        refused <= 1'b1;
      end else if (wr_done && paddr_i == `SBL_REG_STATUS && pwdata_i[`SBL_ST_REFUSED_BIT]) begin
        refused <= 1'b0;
      end
    end
  end

  // ==========================================
  // command sequencer
  logic [12:0] t;
  logic [11:0] beats;
  logic is_rd;
  logic full_r;
  logic reg_r;
  logic [12:0] cap0;
  logic [12:0] lim;

  assign lim = is_rd ? (cap0 + 13'(beats) - 13'h0001) : 13'(beats);
  // capture at edge n+m (+1 when registered), one word per edge
  assign push = (st == sbl_pkg::st_run) && is_rd && (t >= cap0) && ((t - cap0) < 13'(beats)) && fifo_rdy;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= sbl_pkg::st_idle;
      t <= 13'h0000;
      beats <= 12'h001;
      is_rd <= 1'b0;
      full_r <= 1'b0;
      reg_r <= 1'b0;
      cap0 <= 13'h0000;
      mode_cur <= `SBL_MODE_RST;
      mem.cmd <= sbl_pkg::cmd_nop;
      mem.addr <= 12'h000;
      mem.ctl_dq <= '0;
      mem.ctl_dq_oe <= 1'b0;
    end else begin
      mem.cmd <= sbl_pkg::cmd_nop;
      mem.ctl_dq_oe <= 1'b0;
      case (st)
        sbl_pkg::st_idle: begin
          t <= 13'h0001;
          if (go && op_pend == `SBL_OP_LOAD) begin
            // loads only from idle, with no burst open
            mem.cmd <= sbl_pkg::cmd_load;
            mem.addr <= mode_r;
            mode_cur <= mode_r;
            st <= sbl_pkg::st_tail;
          end else if (go) begin
            mem.cmd <= (op_pend == `SBL_OP_READ) ? sbl_pkg::cmd_read : sbl_pkg::cmd_write;
            mem.addr <= {col_r[10], 1'b0, col_r[9:0]};
            beats <= n_go;
            is_rd <= (op_pend == `SBL_OP_READ);
            full_r <= full;
            reg_r <= mem.reg_mode;
            cap0 <= m_lat + 13'h0001;
            st <= sbl_pkg::st_run;
            if (op_pend == `SBL_OP_WRITE && !mem.reg_mode) begin
              mem.ctl_dq <= wbase_r;
              mem.ctl_dq_oe <= 1'b1;
            end
          end
        end
        sbl_pkg::st_run: begin
          t <= t + 13'h0001;
          if (full_r && t == 13'(beats)) begin
            mem.cmd <= sbl_pkg::cmd_term;
          end
          if (!is_rd && (t - 13'(reg_r)) < 13'(beats)) begin
            mem.ctl_dq <= wbase_r + DW'(t - 13'(reg_r));
            mem.ctl_dq_oe <= 1'b1;
          end
          if (t >= lim) begin
            st <= sbl_pkg::st_idle;
          end
        end
        sbl_pkg::st_tail: begin
          t <= t + 13'h0001;
          if (t >= 13'(`SBL_MRD_CYC)) begin
            st <= sbl_pkg::st_idle;
          end
        end
        default: st <= sbl_pkg::st_idle;
      endcase
    end
  end
  // link clock here is 20 MHz, inside every latency limit
endmodule : sbl_ctrl

//--- verif/sbl_assertions.sv
// concurrent checks on the burst link between controller and memory
`timescale 1ns/10ps
module sbl_link_checker (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // link
  input sbl_pkg::sbl_cmd_t cmd,
  input wire logic [11:0] addr,
  input wire logic reg_mode,
  input wire logic ctl_dq_oe,
  input wire logic dev_dq_oe
);
  logic [11:0] mode_q;
  logic rd2;
  logic rd3;
  logic wr0;
  // ==========
  // mode copy
  // loads only come while idle, so no burst straddles an update
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_q <= 12'h020;
    end else if (cmd == sbl_pkg::cmd_load) begin
      mode_q <= addr;
    end
  end
  assign rd2 = cmd == sbl_pkg::cmd_read && mode_q[6:4] == 3'h2;
  assign rd3 = cmd == sbl_pkg::cmd_read && mode_q[6:4] == 3'h3;
  assign wr0 = cmd == sbl_pkg::cmd_write && !reg_mode;
  // ==========
  // properties
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_rd4;
    dev_dq_oe [*4] ##1 !dev_dq_oe;
  endsequence
  sequence s_wr8;
    ctl_dq_oe [*8] ##1 !ctl_dq_oe;
  endsequence
  a_rd_lat2: assert property (rd2 && !reg_mode |-> ##1 !dev_dq_oe ##1 dev_dq_oe)
    else $error("read data late or early at latency two");
  a_rd_lat3: assert property (rd3 && !reg_mode |-> ##2 !dev_dq_oe ##1 dev_dq_oe)
    else $error("read data late or early at latency three");
  a_reg_extra: assert property (rd3 && reg_mode |-> ##3 !dev_dq_oe ##1 dev_dq_oe)
    else $error("registered mode read not one clock later");
  a_span4_beats: assert property (rd2 && !reg_mode && mode_q[2:0] == 3'h2 |-> ##2 s_rd4)
    else $error("span four read beat count wrong");
  a_span8_write: assert property (wr0 && mode_q[2:0] == 3'h3 && !mode_q[9] |-> s_wr8)
    else $error("span eight write beat count wrong");
  a_single_write: assert property (wr0 && mode_q[9] |-> ctl_dq_oe ##1 !ctl_dq_oe)
    else $error("single write drove more than one beat");
  a_one_driver: assert property (!(dev_dq_oe && ctl_dq_oe))
    else $error("both ends drive the data lines");
  a_load_wait: assert property (cmd == sbl_pkg::cmd_load |=> (cmd == sbl_pkg::cmd_nop) [*2])
    else $error("command too soon after mode load");
  a_load_legal: assert property (cmd == sbl_pkg::cmd_load |-> addr[8:7] == 2'h0
    && (addr[2:0] <= 3'h3 || (addr[2:0] == 3'h7 && !addr[3])) && addr[6:5] == 2'h1)
    else $error("reserved mode word loaded");
endmodule : sbl_link_checker

//--- verif/sdram_burst_latency_mode_tb_top.sv
// self-checking bench: controller and memory joined over the burst link
`timescale 1ns/10ps
`include "sbl_map.svh"
module sdram_burst_latency_mode_tb_top;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [11:0] mode_o;
  logic burst_active_o;
  logic [31:0] q;
  logic e;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  // orders table: mode, column, beats, registered mode, bytes expected
  localparam logic [11:0] TM [6] = '{12'h022, 12'h02B, 12'h028, 12'h021, 12'h03A, 12'h033};
  localparam logic [10:0] TC [6] = '{11'h001, 11'h005, 11'h003, 11'h001, 11'h002, 11'h006};
  localparam int TN [6] = '{4, 8, 1, 2, 4, 8};
  localparam logic TR [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  localparam logic [63:0] TX [6] = '{64'h1112131000000000, 64'h1514171611101312,
    64'h1300000000000000, 64'h1110000000000000, 64'h1213101100000000, 64'h1617101112131415};
  sbl_if #(.DW(8)) u_sbl_if ();
  sbl_device #(.DW(8), .COLS(2048)) u_sbl_device (.mem(u_sbl_if), .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .mode_o(mode_o), .burst_active_o(burst_active_o));
  sbl_ctrl #(.DW(8), .DEPTH(32)) u_sbl_ctrl (.mem(u_sbl_if), .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o));
  sbl_link_checker u_sbl_link_checker (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cmd(u_sbl_if.cmd),
    .addr(u_sbl_if.addr), .reg_mode(u_sbl_if.reg_mode), .ctl_dq_oe(u_sbl_if.ctl_dq_oe),
    .dev_dq_oe(u_sbl_if.dev_dq_oe));
  always #25 ref_clk_i = ~ref_clk_i;
  // ==========
  // tasks
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // request held until the edge that sees pready; answer taken at that same edge, only the timeout ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
    end while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk({31'h0, e}, 32'h0);
  endtask : wr
  task automatic op(input logic [1:0] c);
    int n;
    n = 0;
    wr(`SBL_REG_CMD, {30'h0, c});
    do begin
      apb(1'b0, `SBL_REG_STATUS, 32'h0);
      n++;
    end while (q[`SBL_ST_BUSY_BIT] !== 1'b0 && n < 60);
  endtask : op
  task automatic setmode(input logic [11:0] m);
    wr(`SBL_REG_MODE, {20'h0, m});
    op(`SBL_OP_LOAD);
    chk({20'h0, mode_o}, {20'h0, m});
  endtask : setmode
  task automatic rdchk(input logic [10:0] col, input int n, input logic [63:0] x);
    wr(`SBL_REG_COL, {21'h0, col});
    op(`SBL_OP_READ);
    for (int k = 0; k < n; k++) begin
      apb(1'b0, `SBL_REG_RDATA, 32'h0);
      chk(q, {24'h0, x[63-8*k -: 8]});
    end
  endtask : rdchk
  // ==========
  // scenarios
  task automatic t_reset();
    apb(1'b0, `SBL_REG_MODE, 32'h0);
    chk(q, 32'h020);
    apb(1'b0, `SBL_REG_COUNT, 32'h0);
    chk(q, 32'h001);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    apb(1'b1, 8'h06, 32'h5);
    chk({31'h0, e}, 32'h1);
  endtask : t_reset
  task automatic t_orders();
    setmode(12'h023);
    wr(`SBL_REG_WBASE, 32'h10);
    wr(`SBL_REG_COL, 32'h0);
    op(`SBL_OP_WRITE);
    for (int i = 0; i < 6; i++) begin
      wr(`SBL_REG_REGMODE, {31'h0, TR[i]});
      setmode(TM[i]);
      rdchk(TC[i], TN[i], TX[i]);
    end
    wr(`SBL_REG_REGMODE, 32'h0);
  endtask : t_orders
  task automatic t_full();
    wr(`SBL_REG_COUNT, 32'h3);
    setmode(12'h027);
    wr(`SBL_REG_WBASE, 32'h40);
    wr(`SBL_REG_COL, 32'h7FE);
    op(`SBL_OP_WRITE);
    rdchk(11'h7FE, 3, 64'h4041420000000000);
    chk({31'h0, burst_active_o}, 32'h0);
    apb(1'b0, `SBL_REG_STATUS, 32'h0);
    chk(q & 32'h3F00, 32'h0);
  endtask : t_full
  task automatic t_single();
    setmode(12'h222);
    wr(`SBL_REG_WBASE, 32'h80);
    wr(`SBL_REG_COL, 32'h4);
    op(`SBL_OP_WRITE);
    rdchk(11'h004, 4, 64'h8015161700000000);
  endtask : t_single
  // no mode word reaches the memory when it holds a reserved code
  task automatic t_refuse();
    logic [11:0] bad [3];
    bad = '{12'h02F, 12'h0A2, 12'h052};
    for (int i = 0; i < 3; i++) begin
      wr(`SBL_REG_MODE, {20'h0, bad[i]});
      op(`SBL_OP_LOAD);
      chk(q & 32'h1, 32'h1);
      chk({20'h0, mode_o}, 32'h222);
      wr(`SBL_REG_STATUS, 32'h1);
      apb(1'b0, `SBL_REG_STATUS, 32'h0);
      chk(q & 32'h1, 32'h0);
    end
  endtask : t_refuse
  // ==========
  // run
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      report_and_stop();
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_orders();
    t_full();
    t_single();
    t_refuse();
    report_and_stop();
  end
endmodule : sdram_burst_latency_mode_tb_top
